// *** logic/adss_pkg.sv ***
package adss_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
  localparam int GAP_MIN_US    = 5;
  localparam int GAP_MAX_US    = 20;

  // ==========================================================
  // Sample store geometry
  // ==========================================================
  localparam int DEPTH_ENH  = 2048;
  localparam int DEPTH_NORM = 1024;
  localparam int AW         = 11;
  localparam int CW         = 12;
  localparam int DW         = 16;
  localparam int CHW        = 4;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [3:0] IDX_DATA   = 4'h0;
  localparam logic [3:0] IDX_CTRL   = 4'h1;
  localparam logic [3:0] IDX_RANGE  = 4'h2;
  localparam logic [3:0] IDX_GAP    = 4'h3;
  localparam logic [3:0] IDX_COUNT  = 4'h4;
  localparam logic [3:0] IDX_THRESH = 4'h6;
  localparam logic [3:0] IDX_IRQCTL = 4'h9;
  localparam logic [3:0] IDX_STAT   = 4'hA;
  localparam logic [3:0] IDX_CLR    = 4'hB;
  localparam logic [3:0] IDX_EN     = 4'hC;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTL_BUF   = 0;
  localparam int CTL_SCAN  = 1;
  localparam int CTL_ENH   = 2;
  localparam int CTL_SRC   = 3;
  localparam int CTL_START = 4;
  localparam int IRQ_ADIE  = 0;
  localparam int ST_THR    = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_OVF    = 2;
  localparam int ST_W      = 3;
  localparam int COUNT_BSY = 15;
  localparam int THR_SH    = 3;

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [7:0]      CTRL_RST   = 8'h00;
  localparam logic [7:0]      RANGE_RST  = 8'h00;
  localparam logic [7:0]      GAP_RST    = 8'h05;
  localparam logic [7:0]      THRESH_RST = 8'h80;
  localparam logic [7:0]      IRQCTL_RST = 8'h00;
  localparam logic [ST_W-1:0] EN_RST     = 3'h0;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_START,
    SQ_WAIT,
    SQ_GAP
  } adss_state_e;

endpackage

// *** logic/adss_mem.sv ***
`timescale 1ns/1ps
module adss_mem (
  input  wire logic                      clk_i,
  input  wire logic                      we_i,
  input  wire logic [adss_pkg::AW-1:0]   waddr_i,
  input  wire logic [adss_pkg::DW-1:0]   wdata_i,
  input  wire logic [adss_pkg::AW-1:0]   raddr_i,
  output logic      [adss_pkg::DW-1:0]   rdata_o
);
  import adss_pkg::*;

  logic [DW-1:0] mem_q [DEPTH_ENH];

  // ==========================================================
  // Storage write
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // ==========================================================
  // Registered read, new data bypassed on address match
  // ==========================================================
  // Bypass keeps a just-pushed sample visible one cycle later
  always_ff @(posedge clk_i) begin
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

// *** logic/adss_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// [R01] Store holds 2048 samples enhanced, 1024 usable in normal mode.
// [R02] Every finished conversion is pushed, buffering enabled or not; the code drops it and sets overflow when the store is full.
// [R03] Reading the data register returns and removes the oldest sample.
// [R04] Threshold register at index six sets samples before interrupt.
// [R05] Threshold interrupt fires on count, ignoring scan boundaries.
// [R06] Sequencer and store keep up with 250k samples per second; inside a scan the gap of five us or more sets the rate.
// [R07] Scan: each trigger converts low channel through high channel.
// [R08] Gap between scan conversions programmable, five to twenty us.
// [R09] Scan and buffering enables are independent bits.
// [R10] Sequential: each trigger converts the current channel once.
// [R11] Counter steps up when high exceeds low, holds when equal.
// [R12] After high channel the counter reloads the low channel.
// [R13] Mode set by scan, buffering and converter interrupt enables.
// [R14] Software keeps buffering off while converter interrupt is off.
// [R15] Interrupt modes take triggers from timer or external pin only.
// [R16] Threshold request holds until count drops below or cleared.
module adss_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [5:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        timer_tick_i,
  input  wire logic                        ext_trig_i,
  input  wire logic                        conv_done_i,
  input  wire logic [adss_pkg::DW-1:0]     conv_data_i,
  output logic                             conv_start_o,
  output logic      [adss_pkg::CHW-1:0]    conv_chan_o,
  output logic                             irq_o
);
  import adss_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [7:0]      ctrl_q;
  logic [7:0]      range_q;
  logic [7:0]      gap_q;
  logic [7:0]      thresh_q;
  logic [7:0]      irqctl_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] en_q;
  logic [AW-1:0]   wr_ptr_q;
  logic [AW-1:0]   rd_ptr_q;
  logic [CW-1:0]   count_q;
  logic [DW-1:0]   mem_rdata;
  logic            req;
  logic            wr_en;
  logic            rd_en;
  logic [3:0]      idx;
  logic            pop;
  logic            push;
  logic            full;
  logic [CW-1:0]   thr_cnt;
  logic            thr_hit;
  logic            thr_hit_q;
  logic [2:0]      trig_sync_q;
  logic            ext_edge;
  logic            soft_start;
  logic            trigger;
  logic            buf_en;
  logic            scan_en;
  logic            adie;
  logic [CHW-1:0]  lo_ch;
  logic [CHW-1:0]  hi_ch;
  adss_state_e     state_q;
  logic [CHW-1:0]  chan_q;
  logic [6:0]      us_div_q;
  logic            us_tick;
  logic [4:0]      gap_cnt_q;
  logic [4:0]      gap_us;
  logic            scan_last;

  assign buf_en  = ctrl_q[CTL_BUF];    // [R09]
  assign scan_en = ctrl_q[CTL_SCAN];   // [R09]
  assign adie    = irqctl_q[IRQ_ADIE]; // [R13]
  assign lo_ch   = range_q[CHW-1:0];
  assign hi_ch   = range_q[2*CHW-1:CHW];

  // ==========================================================
  // Bus decode
  // ==========================================================
  // One wait state: ack follows the request by one cycle
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx   = wb_adr_i[5:2];
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign rd_en = req && !wb_we_i;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================
  // Control registers
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= CTRL_RST;
      range_q  <= RANGE_RST;
      gap_q    <= GAP_RST;
      thresh_q <= THRESH_RST;
      irqctl_q <= IRQCTL_RST;
      en_q     <= EN_RST;
    end else if (wr_en) begin
      if (hit(idx, IDX_CTRL)) begin
        ctrl_q <= wb_dat_i[7:0] & ~(8'h01 << CTL_START);
      end
      if (hit(idx, IDX_RANGE)) begin
        range_q <= wb_dat_i[7:0];
      end
      if (hit(idx, IDX_GAP)) begin
        gap_q <= wb_dat_i[7:0];
      end
      if (hit(idx, IDX_THRESH)) begin
        thresh_q <= wb_dat_i[7:0]; // [R04]
      end
      if (hit(idx, IDX_IRQCTL)) begin
        irqctl_q <= wb_dat_i[7:0]; // [R13]
      end
      if (hit(idx, IDX_EN)) begin
        en_q <= wb_dat_i[ST_W-1:0];
      end
    end
  end

  // ==========================================================
  // Bus answer
  // ==========================================================
  // Unmapped indices still ack, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd_en) begin
        case (idx)
          IDX_DATA:   wb_dat_o <= (count_q != '0) ?
                                  {16'h0000, mem_rdata} : 32'h0; // [R03]
          IDX_CTRL:   wb_dat_o <= {24'h000000, ctrl_q};
          IDX_RANGE:  wb_dat_o <= {24'h000000, range_q};
          IDX_GAP:    wb_dat_o <= {24'h000000, gap_q};
          IDX_COUNT:  wb_dat_o <= {16'h0000, (state_q != SQ_IDLE),
                                   3'b000, count_q};
          IDX_THRESH: wb_dat_o <= {24'h000000, thresh_q};
          IDX_IRQCTL: wb_dat_o <= {24'h000000, irqctl_q};
          IDX_STAT:   wb_dat_o <= {29'h0, stat_q};
          IDX_EN:     wb_dat_o <= {29'h0, en_q};
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Sample store
  // ==========================================================
  // Normal mode caps usable depth below the physical array
  assign full = ctrl_q[CTL_ENH] ? (count_q == CW'(DEPTH_ENH))
                                : (count_q >= CW'(DEPTH_NORM)); // [R01]
  assign push = conv_done_i && (state_q == SQ_WAIT) && !full; // [R02]
  assign pop  = rd_en && hit(idx, IDX_DATA) && (count_q != '0); // [R03]

  adss_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (push),
    .waddr_i (wr_ptr_q),
    .wdata_i (conv_data_i),
    .raddr_i (rd_ptr_q),
    .rdata_o (mem_rdata)
  );

  // Pointers and fill level; push and pop may share a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1; // [R02]
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1; // [R03]
      end
      case ({push, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // ==========================================================
  // Threshold compare
  // ==========================================================
  // Threshold counts units of eight samples; zero means 2048
  assign thr_cnt = (thresh_q == 8'h00) ? CW'(DEPTH_ENH)
                 : CW'({thresh_q, 3'b000}); // [R04]
  // Count decides while buffering is on, scan position is ignored
  assign thr_hit = buf_en && (count_q >= thr_cnt); // [R05]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_hit_q <= 1'b0;
    end else begin
      thr_hit_q <= thr_hit;
    end
  end

  // ==========================================================
  // Sticky status and interrupt
  // ==========================================================
  // Set beats clear when both land in one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < ST_W; i++) begin
        if (wr_en && hit(idx, IDX_CLR) && wb_dat_i[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (!thr_hit) begin
        stat_q[ST_THR] <= 1'b0; // [R16]
      end
      if (thr_hit && !thr_hit_q) begin
        stat_q[ST_THR] <= 1'b1; // [R05] [R16]
      end
      if (push && !buf_en && (!scan_en || scan_last)) begin
        stat_q[ST_DONE] <= 1'b1;
      end
      if (conv_done_i && (state_q == SQ_WAIT) && full) begin
        stat_q[ST_OVF] <= 1'b1;
      end
    end
  end

  // Converter interrupt enable gates the whole output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= adie && ((stat_q & en_q) != '0); // [R13]
    end
  end

  // ==========================================================
  // Trigger sources
  // ==========================================================
  // Pin passes two flops before the edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_sync_q <= 3'b000;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trig_i};
    end
  end

  assign ext_edge   = trig_sync_q[1] && !trig_sync_q[2];
  assign soft_start = wr_en && hit(idx, IDX_CTRL) && wb_dat_i[CTL_START];
  // Interrupt modes ignore software starts
  assign trigger = (!adie && soft_start) ||
                   (ctrl_q[CTL_SRC] ? ext_edge : timer_tick_i); // [R15]

  // ==========================================================
  // Microsecond divider and scan gap
  // ==========================================================
  assign us_tick = (us_div_q == 7'(US_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != SQ_GAP) begin
      us_div_q <= '0;
    end else begin
      us_div_q <= us_tick ? 7'h00 : us_div_q + 1'b1;
    end
  end

  // Out-of-range settings clamp to the legal span
  assign gap_us = (gap_q < 8'(GAP_MIN_US)) ? 5'(GAP_MIN_US)
                : (gap_q > 8'(GAP_MAX_US)) ? 5'(GAP_MAX_US)
                : gap_q[4:0]; // [R08]

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != SQ_GAP) begin
      gap_cnt_q <= '0;
    end else if (us_tick) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Conversion sequencer
  // ==========================================================
  // A high channel below low behaves like a single channel
  assign scan_last = (chan_q >= hi_ch);

  // Triggers while busy are dropped; sequential triggers are
  // taken right after each done, so 250k per second keeps up
  // Limitation: inside a scan the programmed gap sets the rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SQ_IDLE;
    end else begin
      case (state_q)
        SQ_IDLE: begin
          if (trigger) begin
            state_q <= SQ_START; // [R07] [R10]
          end
        end
        SQ_START: state_q <= SQ_WAIT;
        SQ_WAIT: begin
          if (conv_done_i) begin
            state_q <= (scan_en && !scan_last) ? SQ_GAP
                                               : SQ_IDLE; // [R07] [R06]
          end
        end
        SQ_GAP: begin
          if (us_tick && (gap_cnt_q == gap_us - 1'b1)) begin
            state_q <= SQ_START; // [R08]
          end
        end
        default: state_q <= SQ_IDLE;
      endcase
    end
  end

  // Channel counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= '0;
    end else if (wr_en && hit(idx, IDX_RANGE)) begin
      chan_q <= wb_dat_i[CHW-1:0];
    end else if (state_q == SQ_IDLE && trigger && scan_en) begin
      chan_q <= lo_ch; // [R07]
    end else if (state_q == SQ_WAIT && conv_done_i) begin
      if (scan_last) begin
        chan_q <= lo_ch; // [R12] [R11]
      end else begin
        chan_q <= chan_q + 1'b1; // [R11] [R07]
      end
    end
  end

  // Converter request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      conv_chan_o  <= '0;
    end else begin
      conv_start_o <= (state_q == SQ_START); // [R10]
      if (state_q == SQ_START) begin
        conv_chan_o <= chan_q;
      end
    end
  end

endmodule

// *** bench/adss_chk_properties.sv ***
`timescale 1ns/1ps
// ==========================================
// Port checks of the sampling sequencer
module adss_chk (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [5:0]               wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic                     timer_tick_i,
  input wire logic                     ext_trig_i,
  input wire logic                     conv_done_i,
  input wire logic [adss_pkg::DW-1:0]  conv_data_i,
  input wire logic                     conv_start_o,
  input wire logic [adss_pkg::CHW-1:0] conv_chan_o,
  input wire logic                     irq_o
);
  import adss_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request accepted, and a bus read taken
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read;
    s_take ##0 !wb_we_i;
  endsequence
  property p_ack_take;
    s_take |=> wb_ack_o;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("no ack");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  // Read data moves only after a read was taken
  property p_dat_hold;
    !$past(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("dat moved");
  property p_start_one;
    conv_start_o |=> !conv_start_o [*2];
  endproperty
  a_start_one: assert property (p_start_one) else $error("start");
  property p_chan_hold;
    !conv_start_o |-> $stable(conv_chan_o);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("chan");
  property p_read_ack;
    s_read |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read ack");
  // Reset silences ack, converter start and irq, so no disable here
  property p_rst_quiet;
    disable iff (1'b0) rst_i |=> !wb_ack_o && !conv_start_o && !irq_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("rst");
endmodule

// *** bench/adss_conv_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Converter model: answers each start
module adss_conv_model (
  input  wire logic                     clk_i,
  input  wire logic                     slow_i,
  input  wire logic                     conv_start_i,
  input  wire logic [adss_pkg::CHW-1:0] conv_chan_i,
  output logic                          conv_done_o,
  output logic      [adss_pkg::DW-1:0]  conv_data_o
);
  import adss_pkg::*;
  int             cnt_q = 0;
  logic [CHW-1:0] ch_q  = 4'h0;
  initial conv_done_o = 1'b0;
  initial conv_data_o = 16'h0000;
  // Data only valid with done; toggled between so stale reads show
  always @(posedge clk_i) begin
    conv_done_o <= 1'b0;
    conv_data_o <= ~conv_data_o;
    if (conv_start_i) begin
      cnt_q <= slow_i ? 20 : 2;
      ch_q  <= conv_chan_i;
    end else if (cnt_q == 1) begin
      conv_done_o <= 1'b1;
      conv_data_o <= {12'hC5A, ch_q};
      cnt_q       <= 0;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import adss_pkg::*;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           cyc   = 1'b0;
  logic           stb   = 1'b0;
  logic           we    = 1'b0;
  logic [5:0]     adr   = 6'h00;
  logic [31:0]    wdat  = 32'h0;
  logic           tick  = 1'b0;
  logic           ext   = 1'b0;
  logic           slow  = 1'b0;
  logic [31:0]    rdat;
  logic           ack;
  logic           done;
  logic [DW-1:0]  cdat;
  logic           start;
  logic [CHW-1:0] chan;
  logic           irq;
  logic [31:0]    r;
  int             n;
  int             errors = 0;
  int             checks = 0;
  localparam int  G = GAP_MIN_US * US_CYC;
  always #5 clk_i = ~clk_i;
  // ==========================================
  // Design and converter
  adss_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer_tick_i(tick),
    .ext_trig_i(ext), .conv_done_i(done), .conv_data_i(cdat),
    .conv_start_o(start), .conv_chan_o(chan), .irq_o(irq));
  adss_conv_model u_conv (
    .clk_i(clk_i), .slow_i(slow), .conv_start_i(start),
    .conv_chan_i(chan), .conv_done_o(done), .conv_data_o(cdat));
  // ==========================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Bounded wait; a lost handshake ends the run
  task automatic wfor(ref logic s, input int lim, output int m);
    m = 0;
    do begin
      @(posedge clk_i);
      m++;
    end while (s !== 1'b1 && m < lim);
    if (s !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h000000, d};
    wfor(ack, 20, k);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] i, input logic [31:0] e,
                    input string nm);
    wb(1'b0, i, 8'h00);
    chk(nm, r, e);
  endtask
  task automatic conv1();
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    wfor(start, 20, n);
    r = 32'(chan);
    wfor(done, 50, n);
  endtask
  task automatic ck_irq(input logic e);
    repeat (3) @(posedge clk_i);
    chk("irq", 32'(irq), 32'(e));
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    rc(IDX_THRESH, 32'h80, "thr_rst");
    rc(IDX_IRQCTL, 32'h00, "irqctl_rst");
    rc(4'h5, 32'h0, "unmapped");
    wb(1'b1, IDX_THRESH, 8'h40);
    rc(IDX_THRESH, 32'h40, "thr_rw");
    wb(1'b1, IDX_CTRL, 8'h02);
    rc(IDX_CTRL, 32'h02, "scan_only");
    wb(1'b1, IDX_CTRL, 8'h01);
    rc(IDX_CTRL, 32'h01, "buf_only");
    wb(1'b1, IDX_GAP, 8'h02);
    rc(IDX_GAP, 32'h02, "gap_lo");
    wb(1'b1, IDX_GAP, 8'h1E);
    rc(IDX_GAP, 32'h1E, "gap_hi");
    // Left below the minimum, so the scan gap check sees the clamp
    wb(1'b1, IDX_GAP, 8'h02);
    wb(1'b1, IDX_CTRL, 8'h00);
  endtask
  // Range 2..4 wraps to 2; then a one-channel range stays put
  task automatic t_seq();
    wb(1'b1, IDX_RANGE, 8'h42);
    for (int i = 0; i < 5; i++) begin
      conv1();
      chk("seq_ch", r, 32'(2 + i % 3));
    end
    rc(IDX_COUNT, 32'h5, "seq_cnt");
    for (int i = 0; i < 5; i++) begin
      rc(IDX_DATA, 32'h0000C5A0 | 32'(2 + i % 3), "seq_dat");
    end
    wb(1'b1, IDX_RANGE, 8'h77);
    conv1();
    conv1();
    chk("one_ch", r, 32'h7);
    rc(IDX_DATA, 32'h0000C5A7, "one_dat");
    rc(IDX_DATA, 32'h0000C5A7, "one_dat");
  endtask
  // Soft start of a scan 1..3 with a slow converter
  task automatic t_scan();
    slow <= 1'b1;
    wb(1'b1, IDX_RANGE, 8'h31);
    wb(1'b1, IDX_CTRL, 8'h12);
    for (int i = 1; i <= 3; i++) begin
      wfor(start, 700, n);
      chk("scan_ch", 32'(chan), 32'(i));
      if (i > 1) chk("gap", 32'(n >= G + 15 && n <= G + 40), 32'h1);
    end
    wfor(done, 50, n);
    slow <= 1'b0;
    for (int i = 1; i <= 3; i++) begin
      rc(IDX_DATA, 32'h0000C5A0 | 32'(i), "scan_dat");
    end
  endtask
  task automatic t_irq();
    wb(1'b1, IDX_CLR, 8'h07);
    // Converter interrupt goes on before buffering does
    wb(1'b1, IDX_IRQCTL, 8'h01);
    wb(1'b1, IDX_EN, 8'h01);
    wb(1'b1, IDX_THRESH, 8'h01);
    // Single-channel scans with buffering: count alone decides
    wb(1'b1, IDX_RANGE, 8'h11);
    wb(1'b1, IDX_CTRL, 8'h03);
    repeat (7) conv1();
    ck_irq(1'b0);
    conv1();
    ck_irq(1'b1);
    rc(IDX_STAT, 32'h1, "stat");
    wb(1'b0, IDX_DATA, 8'h00);
    ck_irq(1'b0);
    conv1();
    ck_irq(1'b1);
    wb(1'b1, IDX_CLR, 8'h01);
    ck_irq(1'b0);
    // Buffering goes off before the converter interrupt does
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_IRQCTL, 8'h00);
    wb(1'b1, IDX_EN, 8'h02);
    conv1();
    ck_irq(1'b0);
    wb(1'b1, IDX_IRQCTL, 8'h01);
    ck_irq(1'b1);
    repeat (9) wb(1'b0, IDX_DATA, 8'h00);
    rc(IDX_DATA, 32'h0, "empty");
  endtask
  // Fill normal depth, then enhanced depth, one past each
  task automatic t_full();
    wb(1'b1, IDX_RANGE, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, IDX_CTRL, m ? 8'h04 : 8'h00);
      repeat ((m ? DEPTH_ENH - DEPTH_NORM : DEPTH_NORM) + 1) conv1();
      rc(IDX_COUNT, m ? DEPTH_ENH : DEPTH_NORM, "fill");
      wb(1'b0, IDX_STAT, 8'h00);
      chk("ovf", 32'(r[ST_OVF]), 32'h1);
    end
    rc(IDX_DATA, 32'h0000C5A0, "old");
    repeat (DEPTH_ENH - 1) wb(1'b0, IDX_DATA, 8'h00);
    rc(IDX_COUNT, 32'h0, "drain");
  endtask
  task automatic t_ext();
    wb(1'b1, IDX_CTRL, 8'h08);
    wb(1'b1, IDX_RANGE, 8'h55);
    ext <= 1'b1;
    wfor(start, 20, n);
    chk("ext_ch", 32'(chan), 32'h5);
    ext <= 1'b0;
    wfor(done, 50, n);
    rc(IDX_DATA, 32'h0000C5A5, "ext_dat");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_seq();
    t_scan();
    t_irq();
    t_full();
    t_ext();
    report_and_stop();
  end
endmodule
bind adss_top adss_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timer_tick_i(timer_tick_i),
  .ext_trig_i(ext_trig_i), .conv_done_i(conv_done_i),
  .conv_data_i(conv_data_i), .conv_start_o(conv_start_o),
  .conv_chan_o(conv_chan_o), .irq_o(irq_o));
